/* core/spu_byte_reg.v */
`timescale 1ns/10ps
// One software-writable pointer byte
module spu_byte_reg #(
   parameter [7:0] RESET_VAL = 8'h00
) (
   input  wire       clock_i,
   input  wire       rst_i,
   input  wire       sw_we_i,
   input  wire [7:0] sw_data_i,
   input  wire       hw_we_i,
   input  wire [7:0] hw_data_i,
   output reg  [7:0] value_o
);
   // Software write wins over a same-cycle stack step
   always @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         value_o <= RESET_VAL;
      end else if (sw_we_i) begin
         value_o <= sw_data_i;
      end else if (hw_we_i) begin
         value_o <= hw_data_i;
      end
   end
endmodule // spu_byte_reg

/* core/spu_defines.vh */
`ifndef SPU_DEFINES_VH
`define SPU_DEFINES_VH
// I/O-space addresses of the pointer bytes
`define SPU_ADDR_LOW        6'h3D
`define SPU_ADDR_HIGH       6'h3E
`define SPU_IO_AW           6
// Pointer bytes after reset
`define SPU_RST_LOW         8'h00
`define SPU_RST_HIGH        8'h00
// Pointer step sizes
`define SPU_STEP_BYTE       16'h0001
`define SPU_STEP_ADDR       16'h0002
// Bit positions of the two bytes inside the pointer
`define SPU_HIGH_MSB        15
`define SPU_HIGH_LSB        8
`define SPU_LOW_MSB         7
`define SPU_LOW_LSB         0
`endif

/* core/spu_stack_pointer.v */
`timescale 1ns/10ps
`include "spu_defines.vh"
////////////////////////////////////////////////////////////////////////////
module spu_stack_pointer #(
   parameter HAS_HIGH = 1
) (
   input  wire                   clock_i,
   input  wire                   rst_i,
   input  wire                   push_i,
   input  wire                   pop_i,
   input  wire                   call_i,
   input  wire                   subroutine_return_op_i,
   input  wire                   interrupt_return_op_i,
   input  wire                   io_we_i,
   input  wire                   io_re_i,
   input  wire [`SPU_IO_AW-1:0]  io_addr_i,
   input  wire [7:0]             io_wdata_i,
   output reg  [7:0]             io_rdata_o,
   output reg                    io_hit_o,
   output wire [15:0]            stack_ptr_o,
   output wire [15:0]            sram_addr_o
);
   ////////////////////////////////////////////////////////////////////////
   // Stack operation after priority
   localparam [2:0] OP_IDLE = 3'b000;
   localparam [2:0] OP_PUSH = 3'b001;
   localparam [2:0] OP_CALL = 3'b010;
   localparam [2:0] OP_POP  = 3'b011;
   localparam [2:0] OP_RET  = 3'b100;

   // Pointer byte selected by the I/O address
   localparam [1:0] SEL_NONE = 2'b00;
   localparam [1:0] SEL_LOW  = 2'b01;
   localparam [1:0] SEL_HIGH = 2'b10;

   wire [7:0]  stack_ptr_low;
   wire [7:0]  stack_ptr_high;
   wire [7:0]  high_q;
   wire [15:0] stack_ptr;
   reg  [2:0]  op_code;
   reg         step_en;
   reg         step_up;
   reg  [15:0] step_size;
   wire [15:0] next_ptr;
   wire [7:0]  next_low;
   wire [7:0]  next_high;
   reg  [1:0]  io_sel;
   wire        we_low;
   wire        we_high;
   reg  [7:0]  rdata_d;
   reg         hit_d;

   ////////////////////////////////////////////////////////////////////////
   // Absent high byte reads as zero
   assign stack_ptr_high = (HAS_HIGH != 0) ? high_q : 8'h00;
   assign stack_ptr      = {stack_ptr_high, stack_ptr_low};

   ////////////////////////////////////////////////////////////////////////
   // One operation per cycle: push, call, pop, then returns
   always @* begin
      op_code = OP_IDLE;
      if (push_i) begin
         op_code = OP_PUSH;
      end else if (call_i) begin
         op_code = OP_CALL;
      end else if (pop_i) begin
         op_code = OP_POP;
      // Both return kinds step alike
      end else if (subroutine_return_op_i || interrupt_return_op_i) begin
         op_code = OP_RET;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Downward growth steps
   always @* begin
      step_en   = 1'b1;
      step_up   = 1'b0;
      step_size = `SPU_STEP_BYTE;
      case (op_code)
         OP_PUSH: begin
            step_up   = 1'b0;
            step_size = `SPU_STEP_BYTE;
         end
         OP_CALL: begin
            step_up   = 1'b0;
            step_size = `SPU_STEP_ADDR;
         end
         OP_POP: begin
            step_up   = 1'b1;
            step_size = `SPU_STEP_BYTE;
         end
         OP_RET: begin
            step_up   = 1'b1;
            step_size = `SPU_STEP_ADDR;
         end
         // No operation: pointer holds
         default: begin
            step_en   = 1'b0;
            step_up   = 1'b0;
            step_size = `SPU_STEP_BYTE;
         end
      endcase
   end

   // Wraps modulo the implemented pointer width
   assign next_ptr  = step_up ? (stack_ptr + step_size)
                              : (stack_ptr - step_size);
   assign next_low  = next_ptr[`SPU_LOW_MSB:`SPU_LOW_LSB];
   assign next_high = next_ptr[`SPU_HIGH_MSB:`SPU_HIGH_LSB];

   ////////////////////////////////////////////////////////////////////////
   // I/O address decode
   always @* begin
      case (io_addr_i)
         `SPU_ADDR_LOW: begin
            io_sel = SEL_LOW;
         end
         `SPU_ADDR_HIGH: begin
            io_sel = (HAS_HIGH != 0) ? SEL_HIGH : SEL_NONE;
         end
         default: begin
            io_sel = SEL_NONE;
         end
      endcase
   end

   // Software write next cycle
   // A write beats a same-cycle step for its own byte only
   assign we_low  = io_we_i && (io_sel == SEL_LOW);
   assign we_high = io_we_i && (io_sel == SEL_HIGH);

   ////////////////////////////////////////////////////////////////////////
   // Low pointer byte
   spu_byte_reg #(
      .RESET_VAL (`SPU_RST_LOW)
   ) u_low (
      .clock_i   (clock_i),
      .rst_i     (rst_i),
      .sw_we_i   (we_low),
      .sw_data_i (io_wdata_i),
      .hw_we_i   (step_en),
      .hw_data_i (next_low),
      .value_o   (stack_ptr_low)
   );

   generate
      if (HAS_HIGH != 0) begin : g_high
         spu_byte_reg #(
            .RESET_VAL (`SPU_RST_HIGH)
         ) u_high (
            .clock_i   (clock_i),
            .rst_i     (rst_i),
            .sw_we_i   (we_high),
            .sw_data_i (io_wdata_i),
            .hw_we_i   (step_en),
            .hw_data_i (next_high),
            .value_o   (high_q)
         );
      end else begin : g_no_high
         // Eight-bit pointer wraps inside the low byte
         assign high_q = 8'h00;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // SRAM address from pointer
   // Both outputs are the flopped bytes, no extra logic
   assign stack_ptr_o = stack_ptr;
   assign sram_addr_o = stack_ptr;

   ////////////////////////////////////////////////////////////////////////
   // Read data select
   always @* begin
      hit_d   = 1'b0;
      rdata_d = 8'h00;
      if (io_re_i) begin
         case (io_sel)
            SEL_LOW: begin
               hit_d   = 1'b1;
               rdata_d = stack_ptr_low;
            end
            SEL_HIGH: begin
               hit_d   = 1'b1;
               rdata_d = stack_ptr_high;
            end
            default: begin
               hit_d   = 1'b0;
               rdata_d = 8'h00;
            end
         endcase
      end
   end

   // Registered read data
   // Read data is the byte as it stood at the read edge
   always @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         io_rdata_o <= 8'h00;
         io_hit_o   <= 1'b0;
      end else begin
         io_rdata_o <= rdata_d;
         io_hit_o   <= hit_d;
      end
   end
endmodule // spu_stack_pointer

/* verification/spu_checker.sv */
`timescale 1ns/10ps
module spu_checker (
   input wire        clock_i,
   input wire        rst_i,
   input wire        push_i,
   input wire        pop_i,
   input wire        call_i,
   input wire        subroutine_return_op_i,
   input wire        interrupt_return_op_i,
   input wire        io_we_i,
   input wire        io_re_i,
   input wire [5:0]  io_addr_i,
   input wire [7:0]  io_wdata_i,
   input wire [7:0]  io_rdata_o,
   input wire        io_hit_o,
   input wire [15:0] stack_ptr_o,
   input wire [15:0] sram_addr_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   wire [15:0] p = stack_ptr_o;
   wire w0 = !io_we_i & !push_i;
   wire s = w0 & !call_i;
   wire r = subroutine_return_op_i | interrupt_return_op_i;
   wire rd_hit = io_re_i && (io_addr_i == 6'h3D || io_addr_i == 6'h3E);
   a_push_dec: assert property (push_i & !io_we_i |=>
      p == $past(p) - 16'h0001) else $error("push");
   a_call_dec: assert property (call_i & w0 |=>
      p == $past(p) - 16'h0002) else $error("call");
   a_pop_inc: assert property (pop_i & s |=>
      p == $past(p) + 16'h0001) else $error("pop");
   a_ret_inc: assert property (r & s & !pop_i |=>
      p == $past(p) + 16'h0002) else $error("return");
   a_idle_hold: assert property (s & !pop_i & !r |=> $stable(p))
      else $error("drift");
   a_sram_addr: assert property (sram_addr_o == p)
      else $error("sram");
   a_low_write: assert property (io_we_i && io_addr_i == 6'h3D |=>
      p[7:0] == $past(io_wdata_i)) else $error("low");
   a_high_write: assert property (io_we_i && io_addr_i == 6'h3E |=>
      p[15:8] == $past(io_wdata_i)) else $error("high");
   a_read_low: assert property (io_re_i && io_addr_i == 6'h3D |=>
      io_hit_o && io_rdata_o == $past(p[7:0])) else $error("read");
   a_read_high: assert property (io_re_i && io_addr_i == 6'h3E |=>
      io_hit_o && io_rdata_o == $past(p[15:8])) else $error("read high");
   a_no_hit: assert property (!rd_hit |=>
      !io_hit_o && io_rdata_o == 8'h00) else $error("stray hit");
   cover property (call_i);
   cover property (r);
   cover property (io_hit_o);
   cover property (push_i);
endmodule // spu_checker
bind spu_stack_pointer spu_checker spu_checker_i (
   .clock_i                (clock_i),
   .rst_i                  (rst_i),
   .push_i                 (push_i),
   .pop_i                  (pop_i),
   .call_i                 (call_i),
   .subroutine_return_op_i (subroutine_return_op_i),
   .interrupt_return_op_i  (interrupt_return_op_i),
   .io_we_i                (io_we_i),
   .io_re_i                (io_re_i),
   .io_addr_i              (io_addr_i),
   .io_wdata_i             (io_wdata_i),
   .io_rdata_o             (io_rdata_o),
   .io_hit_o               (io_hit_o),
   .stack_ptr_o            (stack_ptr_o),
   .sram_addr_o            (sram_addr_o)
);

/* verification/spu_cpu_model.sv */
`timescale 1ns/10ps
module spu_cpu_model (
   input  wire        clock_i,
   input  wire        en_i,
   output logic [4:0] op_o
);
   int seed = 32'hec50;
   initial op_o = 5'h00;
   // No stack traffic before the pointer load
   always @(negedge clock_i) begin
      op_o <= en_i ? 5'h01 << ($unsigned($random(seed)) % 6) : 5'h00;
   end
endmodule // spu_cpu_model

/* verification/spu_stack_pointer_tb.sv */
`timescale 1ns/10ps
module spu_stack_pointer_tb;
   logic clock_i = 0, rst_i = 1, we = 0, re = 0, en = 0, hit;
   logic [5:0] ad = 0;
   logic [7:0] wd = 0, rd, e8;
   logic [4:0] op;
   logic [15:0] sp, sa, m = 0, n;
   logic [7:0] q[$];
   int err_total = 0, checks_done = 0, cyc = 0, seed = 32'hec50, r;
`define CMP(a, e) begin checks_done++; if ((a) !== (e)) begin err_total++; \
   $display("[ERR] %0t %h %h", $time, a, e); end end
   initial forever #2.5 clock_i = ~clock_i;
   spu_cpu_model spu_cpu_model_i (.clock_i(clock_i), .en_i(en), .op_o(op));
   spu_stack_pointer spu_stack_pointer_i (.clock_i(clock_i), .rst_i(rst_i),
      .push_i(op[0]), .call_i(op[1]), .pop_i(op[2]),
      .subroutine_return_op_i(op[3]), .interrupt_return_op_i(op[4]),
      .io_we_i(we), .io_re_i(re), .io_addr_i(ad), .io_wdata_i(wd),
      .io_rdata_o(rd), .io_hit_o(hit), .stack_ptr_o(sp), .sram_addr_o(sa));
   always @(posedge clock_i) begin
      n = op[0] ? m - 1 : op[1] ? m - 2 : op[2] ? m + 1 : |op[4:3] ? m + 2 : m;
      if (we && ad == 6'h3D) n[7:0] = wd;
      if (we && ad == 6'h3E) n[15:8] = wd;
      m <= rst_i ? 16'h0000 : n;
      if (++cyc > 5000) begin
         err_total++;
         results;
      end
   end
   always @(negedge clock_i) begin
      if (hit === 1'b1) begin
         e8 = q.pop_front();
         `CMP(rd, e8)
      end
      if (rst_i === 1'b0) begin
         `CMP(sp, m)
         `CMP(sa, m)
      end
   end
   task automatic io(input bit w, input [5:0] a, input [7:0] d);
      @(negedge clock_i);
      {we, re, ad, wd} = {w, !w, a, d};
      if (!w && a != 6'h3F) q.push_back(a[0] ? m[7:0] : m[15:8]);
      @(posedge clock_i);
      we <= 0;
      re <= 0;
   endtask
   task automatic results;
      if (err_total == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clock_i);
      @(negedge clock_i) rst_i = 0;
      io(1, 6'h3E, 8'h04);
      io(0, 6'h3E, 8'h00);
      en = 1;
      repeat (400) begin
         r = $random(seed);
         io(r[0], 6'h3D + 6'(r[2:1] % 3), r[15:8] | 8'h01);
      end
      repeat (3) @(negedge clock_i);
      `CMP(q.size(), 0)
      results;
   end
endmodule // spu_stack_pointer_tb
